// ===== pkg/jpe_pkg.sv
// Constants and types shared by the programming-entry test port design
package jpe_pkg;

  // ****************************************************************
  // Instruction register
  // ****************************************************************
  localparam int         JPE_IR_W           = 4;
  localparam logic [3:0] JPE_INSTR_PROG_EN  = 4'h4;
  localparam logic [3:0] JPE_INSTR_DEV_RST  = 4'hC;
  localparam logic [3:0] JPE_INSTR_BYPASS   = 4'hF;
  localparam logic [3:0] JPE_IR_CAPTURE     = 4'h1;  // Fixed 01 pattern in the low bits
  localparam logic [3:0] JPE_IR_RESET       = 4'hF;  // Bypass after test-logic reset

  // ****************************************************************
  // Data registers
  // ****************************************************************
  localparam int          JPE_SIG_W         = 16;
  localparam logic [15:0] JPE_PROG_SIG      = 16'hA370; // Plain default, not from any part
  localparam logic [15:0] JPE_SIG_RESET     = 16'h0000;

  // ****************************************************************
  // Disable-bit clearing under external reset
  // ****************************************************************
  localparam int          JPE_CLR_CYCLES    = 2;
  localparam logic [1:0]  JPE_CLR_CNT_LAST  = 2'(JPE_CLR_CYCLES - 1);
  localparam logic [1:0]  JPE_CLR_CNT_RESET = 2'h0;

  // ****************************************************************
  // Register map on the AHB-Lite slave
  // ****************************************************************
  localparam logic [7:0]  JPE_CTRL_OFS      = 8'h00;  // mcu_control_status_reg
  localparam logic [7:0]  JPE_STAT_OFS      = 8'h04;  // Test port status
  localparam int          JPE_DIS_POS       = 7;      // test_port_disable_bit
  localparam logic        JPE_DIS_RESET     = 1'b0;
  localparam int          JPE_ST_PROG_POS   = 0;
  localparam int          JPE_ST_DRST_POS   = 1;
  localparam int          JPE_ST_PEN_POS    = 2;
  localparam int          JPE_ST_FUSE_POS   = 3;
  localparam int          JPE_ST_IR_LSB     = 4;
  localparam logic [31:0] JPE_RDATA_RESET   = 32'h0000_0000;

  // ****************************************************************
  // Test access port controller states, one bit apart on each step of the path from reset through Shift-DR to Exit1-DR
  // ****************************************************************
  typedef enum logic [3:0] {
    TAP_RESET   = 4'h0,
    TAP_IDLE    = 4'h1,
    TAP_SEL_DR  = 4'h3,
    TAP_CAP_DR  = 4'h2,
    TAP_SH_DR   = 4'h6,
    TAP_EX1_DR  = 4'h7,
    TAP_PAU_DR  = 4'h5,
    TAP_EX2_DR  = 4'h4,
    TAP_UPD_DR  = 4'hC,
    TAP_SEL_IR  = 4'hD,
    TAP_CAP_IR  = 4'hF,
    TAP_SH_IR   = 4'hE,
    TAP_EX1_IR  = 4'hA,
    TAP_PAU_IR  = 4'hB,
    TAP_EX2_IR  = 4'h9,
    TAP_UPD_IR  = 4'h8
  } jpe_tap_e;

endpackage

// ===== rtl/jpe_tap_fsm.sv
// Test access port controller state machine, clocked by the test clock
module jpe_tap_fsm
  import jpe_pkg::*;
(
  // Clock and reset
  input  wire logic     tck,
  input  wire logic     rst,
  // Hold in test-logic reset while the port is not usable
  input  wire logic     forceReset,
  // Mode select pin
  input  wire logic     tms,
  // Current state
  output jpe_tap_e      state_ff
);

  jpe_tap_e nxt_state;

  // ****************************************************************
  // Next state from the mode select pin
  // ****************************************************************
  always_comb begin
    case (state_ff)
      TAP_RESET:  nxt_state = tms ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   nxt_state = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: nxt_state = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: nxt_state = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  nxt_state = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: nxt_state = tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: nxt_state = tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: nxt_state = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: nxt_state = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: nxt_state = tms ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: nxt_state = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  nxt_state = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: nxt_state = tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: nxt_state = tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: nxt_state = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: nxt_state = tms ? TAP_SEL_DR : TAP_IDLE;
      default:    nxt_state = TAP_RESET;
    endcase
  end

  // State register; a disabled port parks the controller in reset
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      state_ff <= TAP_RESET;
    end else if (forceReset) begin
      state_ff <= TAP_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

endmodule

// ===== rtl/jpe_jtag_prog_entry.sv
// Test port front end for entering non-volatile programming mode

// How it works
// - Port is usable only with the enable fuse programmed and disable bit clear.
// - Disable bit set and external reset low: bit clears after two chip clocks.
// - Instruction register is four bits, room for sixteen instructions.
// - Each instruction connects one data register between data in and out.
// - Run-Test/Idle makes internal clock pulses; also usable as idle gap.
// - Device reset instruction selects one-bit reset chain; controller not reset.
// - Device stays in reset exactly while the chain bit is one, unlatched.
// - Under device reset instruction only Shift-DR acts, shifting the chain.
// - Programming-enable instruction selects sixteen-bit signature register, shifted in.
// - On Update-DR a matching signature switches programming mode on.
module jpe_jtag_prog_entry
  import jpe_pkg::*;
(
  // Chip clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Device pins seen by the chip clock domain
  input  wire logic        extResetN,
  input  wire logic        testPortEnableFuse,
  // Test port pins
  input  wire logic        tck,
  input  wire logic        tms,
  input  wire logic        tdi,
  output logic             tdo,
  output logic             tdoOe,
  // Results toward the rest of the device, test clock domain
  output logic             deviceReset,
  output logic             progMode,
  output logic             internalClkPulse
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  // Chip clock domain
  logic        fuseMeta_ff;
  logic        fuseSync_ff;
  logic        extRstMeta_ff;
  logic        extRstNSync_ff;
  logic        disable_ff;
  logic        nxt_disable;
  logic [1:0]  clrCnt_ff;
  logic [1:0]  nxt_clrCnt;
  logic        clrArmed;
  logic        clrDone;
  logic        portEnable;
  logic        progMeta_ff;
  logic        progSync_ff;
  logic        drstMeta_ff;
  logic        drstSync_ff;
  // AHB slave
  logic        addrPhase;
  logic        wrPend_ff;
  logic [7:0]  wrAddr_ff;
  logic        ctrlWrite;
  logic        rdCtrlHit;
  logic        rdStatHit;
  logic [31:0] ctrlWord;
  logic [31:0] statWord;
  logic [31:0] rdWord;
  logic [3:0]  instrMeta_ff;
  logic [3:0]  instrSync_ff;
  logic [3:0]  instrHold_ff;
  logic [3:0]  instrShow_ff;
  logic        instrSteady;
  // Test clock domain
  logic        enMeta_ff;
  logic        enSync_ff;
  jpe_tap_e    tapState;
  logic [3:0]  irShift_ff;
  logic [3:0]  instr_ff;
  logic        resetChain_ff;
  logic [15:0] sigShift_ff;
  logic        bypass_ff;
  logic        progMode_ff;
  logic        pulse_ff;
  logic        tdo_ff;
  logic        tdoOe_ff;
  logic        selDevRst;
  logic        selProgEn;
  logic        selBypass;
  logic        capIr;
  logic        shIr;
  logic        updIr;
  logic        shDr;
  logic        updDr;
  logic        capDr;
  logic        sigMatch;
  logic        drOut;
  logic        scanOut;

  // ****************************************************************
  // Pin synchronisers into the chip clock
  // ****************************************************************
  // Two stages each; only the second stage feeds logic
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fuseMeta_ff    <= 1'b0;
      fuseSync_ff    <= 1'b0;
      extRstMeta_ff  <= 1'b1;
      extRstNSync_ff <= 1'b1;
    end else begin
      fuseMeta_ff    <= testPortEnableFuse;
      fuseSync_ff    <= fuseMeta_ff;
      extRstMeta_ff  <= extResetN;
      extRstNSync_ff <= extRstMeta_ff;
    end
  end

  // ****************************************************************
  // Port disable bit and its reset-assisted clearing
  // ****************************************************************
  // Count chip clocks while the bit is set and external reset is low
  assign clrArmed   = disable_ff & ~extRstNSync_ff;
  assign clrDone    = clrArmed & (clrCnt_ff == JPE_CLR_CNT_LAST);
  assign nxt_clrCnt = clrArmed ? (clrDone ? clrCnt_ff : clrCnt_ff + 2'h1)
                               : JPE_CLR_CNT_RESET;

  // A software write lands over the hardware clear in the same cycle
  assign nxt_disable = ctrlWrite ? hwdata[JPE_DIS_POS]
                     : (clrDone  ? 1'b0 : disable_ff);

  // Port usable only with fuse programmed and disable bit clear
  assign portEnable = fuseSync_ff & ~disable_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      disable_ff <= JPE_DIS_RESET;
      clrCnt_ff  <= JPE_CLR_CNT_RESET;
    end else begin
      disable_ff <= nxt_disable;
      clrCnt_ff  <= nxt_clrCnt;
    end
  end

  // Status from the test clock domain, two stages each
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      progMeta_ff <= 1'b0;
      progSync_ff <= 1'b0;
      drstMeta_ff <= 1'b0;
      drstSync_ff <= 1'b0;
    end else begin
      progMeta_ff <= progMode_ff;
      progSync_ff <= progMeta_ff;
      drstMeta_ff <= resetChain_ff;
      drstSync_ff <= drstMeta_ff;
    end
  end

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  // Zero wait states; unmapped offsets read zero and ignore writes
  assign addrPhase = hsel & htrans[1] & hready;
  assign ctrlWrite = wrPend_ff & (wrAddr_ff == JPE_CTRL_OFS);
  assign rdCtrlHit = addrPhase & ~hwrite & (haddr[7:0] == JPE_CTRL_OFS);
  assign rdStatHit = addrPhase & ~hwrite & (haddr[7:0] == JPE_STAT_OFS);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Read words; reserved bits read zero
  assign ctrlWord = {24'h00_0000, disable_ff, 7'h00};
  assign statWord = {24'h00_0000, instrShow_ff, fuseSync_ff, portEnable,
                     drstSync_ff, progSync_ff};
  assign rdWord   = rdCtrlHit ? ctrlWord
                  : (rdStatHit ? statWord : JPE_RDATA_RESET);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPend_ff <= 1'b0;
      wrAddr_ff <= 8'h00;
      hrdata    <= JPE_RDATA_RESET;
    end else begin
      wrPend_ff <= addrPhase & hwrite;
      wrAddr_ff <= haddr[7:0];
      hrdata    <= addrPhase ? rdWord : hrdata;
    end
  end

  // Current instruction shown in status; the four bits cross together, so
  // a sample caught mid-change is not shown until two samples agree
  assign instrSteady = (instrSync_ff == instrHold_ff);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      instrMeta_ff <= JPE_IR_RESET;
      instrSync_ff <= JPE_IR_RESET;
      instrHold_ff <= JPE_IR_RESET;
      instrShow_ff <= JPE_IR_RESET;
    end else begin
      instrMeta_ff <= instr_ff;
      instrSync_ff <= instrMeta_ff;
      instrHold_ff <= instrSync_ff;
      instrShow_ff <= instrSteady ? instrSync_ff : instrShow_ff;
    end
  end

  // ****************************************************************
  // Enable into the test clock domain
  // ****************************************************************
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      enMeta_ff <= 1'b0;
      enSync_ff <= 1'b0;
    end else begin
      enMeta_ff <= portEnable;
      enSync_ff <= enMeta_ff;
    end
  end

  // Controller driven by the test clock and mode pins, held in reset while the port is disabled
  jpe_tap_fsm u_tap (
    .tck        (tck),
    .rst        (rst),
    .forceReset (~enSync_ff),
    .tms        (tms),
    .state_ff   (tapState)
  );

  // ****************************************************************
  // State decode and instruction select
  // ****************************************************************
  assign capIr = (tapState == TAP_CAP_IR);
  assign shIr  = (tapState == TAP_SH_IR);
  assign updIr = (tapState == TAP_UPD_IR);
  assign capDr = (tapState == TAP_CAP_DR);
  assign shDr  = (tapState == TAP_SH_DR);
  assign updDr = (tapState == TAP_UPD_DR);

  // One data register per instruction; unknown codes fall to bypass
  assign selDevRst = (instr_ff == JPE_INSTR_DEV_RST);
  assign selProgEn = (instr_ff == JPE_INSTR_PROG_EN);
  assign selBypass = ~selDevRst & ~selProgEn;
  assign sigMatch  = (sigShift_ff == JPE_PROG_SIG);

  // ****************************************************************
  // Instruction register
  // ****************************************************************
  // Four-bit shift stage and update stage
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      irShift_ff <= JPE_IR_RESET;
      instr_ff   <= JPE_IR_RESET;
    end else if (tapState == TAP_RESET) begin
      irShift_ff <= JPE_IR_RESET;
      instr_ff   <= JPE_IR_RESET;
    end else begin
      if (capIr) begin
        irShift_ff <= JPE_IR_CAPTURE;
      end else if (shIr) begin
        irShift_ff <= {tdi, irShift_ff[JPE_IR_W-1:1]};
      end
      if (updIr) begin
        instr_ff <= irShift_ff;
      end
    end
  end

  // ****************************************************************
  // Data registers
  // ****************************************************************
  // Reset chain: acts only in Shift-DR, no capture or update stage;
  // the controller state is untouched by it
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      resetChain_ff <= 1'b0;
    end else if (selDevRst & shDr) begin
      resetChain_ff <= tdi;
    end
  end

  // Signature register shifts the enable signature in, lsb first
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      sigShift_ff <= JPE_SIG_RESET;
    end else if (selProgEn & shDr) begin
      sigShift_ff <= {tdi, sigShift_ff[JPE_SIG_W-1:1]};
    end
  end

  // Bypass bit for every other code
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      bypass_ff <= 1'b0;
    end else if (selBypass & capDr) begin
      bypass_ff <= 1'b0;
    end else if (selBypass & shDr) begin
      bypass_ff <= tdi;
    end
  end

  // Programming mode: set on a matching update, kept on a mismatch,
  // left by test-logic reset
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      progMode_ff <= 1'b0;
    end else if (tapState == TAP_RESET) begin
      progMode_ff <= 1'b0;
    end else if (selProgEn & updDr & sigMatch) begin
      progMode_ff <= 1'b1;
    end
  end

  // Internal clock pulse for each test clock spent in Run-Test/Idle
  always_ff @(posedge tck or posedge rst) begin
    if (rst) begin
      pulse_ff <= 1'b0;
    end else begin
      pulse_ff <= (tapState == TAP_IDLE);
    end
  end

  // ****************************************************************
  // Serial output
  // ****************************************************************
  assign drOut   = selDevRst ? resetChain_ff
                 : (selProgEn ? sigShift_ff[0] : bypass_ff);
  assign scanOut = shIr ? irShift_ff[0] : drOut;

  // Data out changes on the falling test clock, as the scan path expects
  always_ff @(negedge tck or posedge rst) begin
    if (rst) begin
      tdo_ff   <= 1'b0;
      tdoOe_ff <= 1'b0;
    end else begin
      tdo_ff   <= scanOut;
      tdoOe_ff <= shIr | shDr;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign tdo              = tdo_ff;
  assign tdoOe            = tdoOe_ff;
  assign deviceReset      = resetChain_ff;
  assign progMode         = progMode_ff;
  assign internalClkPulse = pulse_ff;

endmodule

// ===== dv/jpe_jtag_prog_entry_asserts.sv
// Concurrent checks on the programming-entry test port
// ********
// Checker
// ********
module jpe_prog_entry_asserts
  import jpe_pkg::*;
(
  // Chip clock domain
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        testPortEnableFuse,
  // Test clock domain
  input wire logic        tck,
  input wire logic        tms,
  input wire logic        tdi,
  input wire logic        tdoOe,
  input wire logic        deviceReset,
  input wire logic        progMode,
  input wire logic        internalClkPulse
);
  logic [15:0] sigSeen_ff;

  // Last sixteen bits scanned in while shifting, to judge any entry into programming mode
  always_ff @(posedge tck or posedge rst) begin
    if (rst)
      sigSeen_ff <= 16'h0000;
    else if (tdoOe)
      sigSeen_ff <= {tdi, sigSeen_ff[15:1]};
  end

  a_ready_high: assert property (@(posedge clk) disable iff (rst) hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (@(posedge clk) disable iff (rst) !hresp)
    else $error("hresp not OKAY");
  a_rdata_upper: assert property (@(posedge clk) disable iff (rst)
    hrdata[31:8] == 24'h000000) else $error("read data upper bits set");
  // Fuse held off across many test clocks keeps the port dead
  a_fuse_blocks: assert property (@(posedge tck) disable iff (rst)
    (!testPortEnableFuse)[*8] |-> !tdoOe && !progMode) else $error("port alive, fuse off");
  a_prog_on_upd: assert property (@(posedge tck) disable iff (rst)
    $rose(progMode) |-> $past(tms, 2) && $past(tms, 3)) else $error("mode rose off Update-DR");
  a_prog_sig: assert property (@(posedge tck) disable iff (rst)
    $rose(progMode) |-> $past(sigSeen_ff) == JPE_PROG_SIG) else $error("mode on bad signature");
  a_rst_chain: assert property (@(posedge tck) disable iff (rst)
    $changed(deviceReset) |-> $past(tdoOe) && deviceReset == $past(tdi))
    else $error("reset chain moved outside a shift");
  a_pulse_gap: assert property (@(posedge tck) disable iff (rst)
    internalClkPulse |-> !tdoOe) else $error("internal pulse while shifting");
endmodule

bind jpe_jtag_prog_entry jpe_prog_entry_asserts i_asserts (
  .clk(clk), .rst(rst), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .testPortEnableFuse(testPortEnableFuse), .tck(tck), .tms(tms), .tdi(tdi),
  .tdoOe(tdoOe), .deviceReset(deviceReset), .progMode(progMode),
  .internalClkPulse(internalClkPulse)
);

// ===== dv/jpe_prog_model.sv
// Behavioural test-port programmer driving three of the four port pins and reading data out
// ********
// Programmer model
// ********
module jpe_prog_model
  import jpe_pkg::*;
(
  // Test port pins toward the device
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  timeunit 1ns;
  timeprecision 100ps;

  // Only the four port pins are used; clock rests low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One 6 ns test clock: pins move while low, data out taken at the rise
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #3 tck = 1'b1;
    o = tdo;
    #3 tck = 1'b0;
  endtask

  // Walk the controller with a mode pattern, lsb first
  task automatic walk(input logic [7:0] pat, input int n);
    logic o;
    for (int i = 0; i < n; i++)
      step(pat[i], 1'b0, o);
  endtask

  // Shift n bits lsb first, leaving the shift state on the last one
  task automatic shift(input logic [15:0] v, input int n, output logic [15:0] cap);
    logic o;
    cap = 16'h0000;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, v[i], o);
      cap[i] = o;
    end
  endtask

  // Park in Run-Test/Idle for n clocks as a gap
  task automatic idle(input int n);
    walk(8'h00, n);
  endtask

  // Five mode-high clocks reach test-logic reset, then park in Idle
  task automatic tlr();
    walk(8'h1F, 6);
  endtask

  // Instruction scan from Idle back to Idle
  task automatic ir(input logic [3:0] c, output logic [15:0] cap);
    walk(8'h03, 4);
    shift({12'h000, c}, 4, cap);
    walk(8'h01, 2);
  endtask

  // Data scan from Idle back to Idle
  task automatic dr(input logic [15:0] v, input int n, output logic [15:0] cap);
    walk(8'h01, 3);
    shift(v, n, cap);
    walk(8'h01, 2);
  endtask
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the programming-entry test port
// ********
// Bench
// ********
module tb_top
  import jpe_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic        extResetN, testPortEnableFuse, tck, tms, tdi, tdo, tdoOe;
  logic        deviceReset, progMode, internalClkPulse;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] cap;
  int          numErrors, checked, pulses;

  // The one slave drives the bus ready
  assign hready = hreadyout;

  jpe_jtag_prog_entry i_dut (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .extResetN(extResetN), .testPortEnableFuse(testPortEnableFuse),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe), .deviceReset(deviceReset),
    .progMode(progMode), .internalClkPulse(internalClkPulse)
  );

  jpe_prog_model i_prog (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  // 100 MHz chip clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Pulses are read before this edge's updates land
  always @(posedge tck) begin
    if (internalClkPulse === 1'b1)
      pulses++;
  end

  task automatic complete_run();
    if (numErrors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      numErrors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    check({31'h0, got}, {31'h0, exp});
  endtask

  // One single AHB-Lite transfer; a stuck bus ends the run
  task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
    int n;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, ofs};
    hwrite <= wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin
      numErrors++;
      complete_run();
    end
  endtask

  task automatic rdchk(input logic [7:0] ofs, input logic [31:0] exp);
    ahb(1'b0, ofs, 32'h00000000);
    check(rd, exp);
  endtask

  // Signature scan under the enable instruction, from a fresh controller
  task automatic enter(input logic [15:0] sig);
    i_prog.tlr();
    i_prog.ir(JPE_INSTR_PROG_EN, cap);
    i_prog.dr(sig, 16, cap);
  endtask

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 32'h00000000;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    extResetN = 1'b1;
    testPortEnableFuse = 1'b1;
    numErrors = 0;
    checked = 0;
    pulses = 0;
    i_prog.walk(8'h03, 2);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    // Register defaults, an unmapped place and the one writable bit
    rdchk(JPE_CTRL_OFS, 32'h00000000);
    rdchk(JPE_STAT_OFS, 32'h000000FC);
    rdchk(8'h08, 32'h00000000);
    ahb(1'b1, JPE_CTRL_OFS, 32'hFFFFFFFF);
    rdchk(JPE_CTRL_OFS, 32'h00000080);
    ahb(1'b1, JPE_CTRL_OFS, 32'h00000000);
    // Reset chain: instruction capture, set, unlatched reset, shift back out
    i_prog.tlr();
    i_prog.ir(JPE_INSTR_DEV_RST, cap);
    check({28'h0, cap[3:0]}, {28'h0, JPE_IR_CAPTURE});
    i_prog.dr(16'h0001, 1, cap);
    chkb(deviceReset, 1'b1);
    repeat (5) @(posedge clk);
    rdchk(JPE_STAT_OFS, 32'h000000CE);
    i_prog.dr(16'h0000, 2, cap);
    check({30'h0, cap[1:0]}, 32'h00000001);
    chkb(deviceReset, 1'b0);
    // Bypass puts one captured zero ahead of the data
    i_prog.ir(JPE_INSTR_BYPASS, cap);
    i_prog.dr(16'h0001, 2, cap);
    check({30'h0, cap[1:0]}, 32'h00000002);
    // Near miss in the last bit, the match, then a miss while on
    enter(JPE_PROG_SIG ^ 16'h8000);
    chkb(progMode, 1'b0);
    i_prog.dr(JPE_PROG_SIG, 16, cap);
    chkb(progMode, 1'b1);
    i_prog.dr(~JPE_PROG_SIG, 16, cap);
    chkb(progMode, 1'b1);
    repeat (5) @(posedge clk);
    rdchk(JPE_STAT_OFS, 32'h0000004D);
    pulses = 0;
    i_prog.idle(8);
    check(pulses, 32'h00000007);
    i_prog.tlr();
    chkb(progMode, 1'b0);
    // Disable bit kills the port
    @(posedge clk);
    ahb(1'b1, JPE_CTRL_OFS, 32'h00000080);
    repeat (5) @(posedge clk);
    rdchk(JPE_STAT_OFS, 32'h000000F8);
    enter(JPE_PROG_SIG);
    chkb(progMode, 1'b0);
    // External reset low clears the bit, not before its second clock
    @(posedge clk);
    extResetN <= 1'b0;
    @(posedge clk);
    rdchk(JPE_CTRL_OFS, 32'h00000080);
    rdchk(JPE_CTRL_OFS, 32'h00000080);
    rdchk(JPE_CTRL_OFS, 32'h00000000);
    extResetN <= 1'b1;
    repeat (3) @(posedge clk);
    enter(JPE_PROG_SIG);
    chkb(progMode, 1'b1);
    // Fuse off: port stays dead
    i_prog.tlr();
    @(posedge clk);
    testPortEnableFuse <= 1'b0;
    repeat (4) @(posedge clk);
    rdchk(JPE_STAT_OFS, 32'h000000F0);
    enter(JPE_PROG_SIG);
    chkb(progMode, 1'b0);
    complete_run();
  end
endmodule
